/* File: common/wdt_pkg.sv */
// constants, offsets and helpers for the low-frequency watchdog
//
// Behaviour
// - An overflow of the watchdog counter raises a system reset request that resets the whole controller.
// - After any system reset the watchdog runs at once, with no software action, at its longest timeout.
// - While unlocked, software may disable the watchdog so that no overflow reset can happen.
// - Once locked on, every attempt to disable it is ignored until the next system reset.
// - While locked, every change to the configuration, timeout included, is refused until a system reset.
// - An overflow reset never drives or changes the external reset pin.
// - The counter advances on the internal low-frequency oscillator, not the system clock, with a selectable timeout.
// - Leaving a watchdog reset, execution restarts at address zero on an internal clock with the watchdog on.
package wdt_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int              ADDR_W        = 12;
    localparam logic [11:0]     CTRL_OFF      = 12'h000;
    localparam logic [11:0]     KICK_OFF      = 12'h004;
    localparam logic [11:0]     STAT_OFF      = 12'h008;
    localparam logic [11:0]     COUNT_OFF     = 12'h00C;

    // ****************************************************************
    // fields
    // ****************************************************************
    localparam int              EN_BIT        = 0;
    localparam int              LOCK_BIT      = 1;
    localparam int              SEL_LSB       = 2;
    localparam int              SEL_W         = 3;
    localparam int              REJ_BIT       = 2;
    localparam int              REQ_BIT       = 3;
    localparam int              KEY_W         = 8;
    localparam logic [7:0]      KICK_KEY      = 8'hA5;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic            EN_RST        = 1'b1;
    localparam logic            LOCK_RST      = 1'b0;
    localparam logic [2:0]      SEL_RST       = 3'h7;
    localparam logic [15:0]     RESET_VECTOR  = 16'h0000;
    localparam logic            BOOT_CLK_INT  = 1'b1;

    // ****************************************************************
    // counter sizing
    // ****************************************************************
    localparam int              CNT_W         = 14;
    localparam int              TMO_BASE      = 6;

    // overflow point for a timeout selection: 2^(base+sel) oscillator ticks
    function automatic logic [CNT_W-1:0] tmo_limit(input logic [SEL_W-1:0] sel);
        logic [CNT_W:0] one_hot;
        one_hot = '0;
        one_hot[TMO_BASE + int'(sel)] = 1'b1;
        return CNT_W'(one_hot - 1'b1);
    endfunction

endpackage

/* File: common/wdt_if.sv */
// signals between the watchdog control, tick synchroniser and counter
`timescale 1ns/1ns
`default_nettype none
interface wdt_if;
    logic                           tick;
    logic                           run;
    logic                           kick;
    logic [wdt_pkg::SEL_W-1:0]      sel;
    logic [wdt_pkg::CNT_W-1:0]      count;
    logic                           overflow;

    modport src  (output tick);
    modport ctl  (output run, kick, sel, input count, overflow);
    modport core (input tick, run, kick, sel, output count, overflow);
endinterface
`default_nettype wire

/* File: hw/lf_tick_sync.sv */
// brings the low-frequency oscillator into the pclk domain as a one-cycle tick
`timescale 1ns/1ns
`default_nettype none
module lf_tick_sync
    import wdt_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   low_freq_osc,
    wdt_if.src          wd
);
    logic               meta_r;
    logic               sync_r;
    logic               prev_r;

    // ****************************************************************
    // two-stage synchroniser and rising edge detect
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= low_freq_osc;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign wd.tick = sync_r & ~prev_r;
endmodule
`default_nettype wire

/* File: hw/watchdog_counter.sv */
// watchdog up-counter on low-frequency ticks with sticky overflow
`timescale 1ns/1ns
`default_nettype none
module watchdog_counter
    import wdt_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    wdt_if.core         wd
);
    logic [CNT_W-1:0]   count_r;
    logic               ovf_r;
    logic               at_limit;

    assign at_limit = (count_r == tmo_limit(wd.sel));

    // ****************************************************************
    // counter
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r <= '0;
        end
        else if (!wd.run || wd.kick)
        begin
            count_r <= '0;
        end
        else if (wd.tick && !at_limit)
        begin
            count_r <= count_r + 1'b1;
        end
    end

    // ****************************************************************
    // overflow, held until system reset
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovf_r <= 1'b0;
        end
        else if (wd.run && !wd.kick && wd.tick && at_limit)
        begin
            ovf_r <= 1'b1;
        end
    end

    assign wd.count    = count_r;
    assign wd.overflow = ovf_r;
endmodule
`default_nettype wire

/* File: hw/lowfreq_watchdog_reset.sv */
// watchdog top: apb registers, lock control and system reset request
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module lowfreq_watchdog_reset
    import wdt_pkg::*;
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [wdt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output var  logic [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       low_freq_osc,
    output var  logic                       sys_reset_req,
    output logic                            ext_rst_pin_oe,
    output logic [15:0]                     reset_vector,
    output logic                            boot_clk_internal
);
    import wdt_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    wdt_if                  wd ();

    logic                   en_r;
    logic                   lock_r;
    logic [SEL_W-1:0]       sel_r;
    logic                   rej_r;
    logic                   req_r;
    logic [31:0]            rdata_r;

    logic                   setup;
    logic                   access;
    logic                   wr;
    logic                   mapped;
    logic                   wr_ctrl;
    logic                   wr_kick;
    logic                   wr_stat;
    logic                   ctrl_refused;
    logic [31:0]            rd_mux;

    // ****************************************************************
    // submodules
    // ****************************************************************
    lf_tick_sync u_sync
    (
        .pclk         (pclk),
        .presetn      (presetn),
        .low_freq_osc (low_freq_osc),
        .wd           (wd.src)
    );

    watchdog_counter u_counter
    (
        .pclk    (pclk),
        .presetn (presetn),
        .wd      (wd.core)
    );

    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign wr      = access & pwrite;

    always_comb
    begin
        case (paddr)
            CTRL_OFF,
            KICK_OFF,
            STAT_OFF,
            COUNT_OFF: mapped = 1'b1;
            default:   mapped = 1'b0;
        endcase
    end

    assign wr_ctrl      = wr & (paddr == CTRL_OFF);
    assign wr_kick      = wr & (paddr == KICK_OFF) & (pwdata[KEY_W-1:0] == KICK_KEY);
    assign wr_stat      = wr & (paddr == STAT_OFF);
    assign ctrl_refused = wr_ctrl & lock_r;

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ****************************************************************
    // enable, reset to running after every system reset
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_r <= EN_RST;
        end
        else if (wr_ctrl && !lock_r)
        begin
            // locking forces the watchdog on
            en_r <= pwdata[EN_BIT] | pwdata[LOCK_BIT];
        end
    end

    // ****************************************************************
    // lock, cleared only by system reset
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_r <= LOCK_RST;
        end
        else if (wr_ctrl && pwdata[LOCK_BIT])
        begin
            lock_r <= 1'b1;
        end
    end

    // ****************************************************************
    // timeout selection, longest after reset
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_r <= SEL_RST;
        end
        else if (wr_ctrl && !lock_r)
        begin
            sel_r <= pwdata[SEL_LSB +: SEL_W];
        end
    end

    // ****************************************************************
    // refused-write flag, write 1 to clear, set wins
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rej_r <= 1'b0;
        end
        else if (ctrl_refused)
        begin
            rej_r <= 1'b1;
        end
        else if (wr_stat && pwdata[REJ_BIT])
        begin
            rej_r <= 1'b0;
        end
    end

    // ****************************************************************
    // system reset request, held until the reset arrives
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_r <= 1'b0;
        end
        else if (wd.overflow)
        begin
            req_r <= 1'b1;
        end
    end

    assign sys_reset_req = req_r;

    // internal reset only: the pin driver is never enabled
    assign ext_rst_pin_oe = 1'b0;

    // restart point and clock choice seen by the core after reset
    assign reset_vector      = RESET_VECTOR;
    assign boot_clk_internal = BOOT_CLK_INT;

    // ****************************************************************
    // counter control
    // ****************************************************************
    assign wd.run  = en_r;
    assign wd.kick = wr_kick;
    assign wd.sel  = sel_r;

    // ****************************************************************
    // read data, captured in the setup cycle
    // ****************************************************************
    always_comb
    begin
        rd_mux = '0;
        case (paddr)
            CTRL_OFF:
            begin
                rd_mux[EN_BIT]               = en_r;
                rd_mux[LOCK_BIT]             = lock_r;
                rd_mux[SEL_LSB +: SEL_W]     = sel_r;
            end
            STAT_OFF:
            begin
                rd_mux[EN_BIT]               = en_r;
                rd_mux[LOCK_BIT]             = lock_r;
                rd_mux[REJ_BIT]              = rej_r;
                rd_mux[REQ_BIT]              = req_r;
            end
            COUNT_OFF:
            begin
                rd_mux[CNT_W-1:0]            = wd.count;
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_r <= '0;
        end
        else if (setup && !pwrite)
        begin
            rdata_r <= rd_mux;
        end
    end

    assign prdata = rdata_r;
endmodule
`default_nettype wire

/* File: verif/wdt_checker.sv */
// port assertions for the low-frequency watchdog
`timescale 1ns/1ns
`default_nettype none
module wdt_checker
    import wdt_pkg::*;
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       low_freq_osc,
    input wire logic                       sys_reset_req,
    input wire logic                       ext_rst_pin_oe,
    input wire logic [15:0]                reset_vector,
    input wire logic                       boot_clk_internal
);
    // ********
    // helpers
    // ********
    logic        acc_w, acc_r, lock_h, cfg_h, osc_m, osc_s, osc_q, osc_tick;
    logic [14:0] ticks;
    assign acc_w    = psel && penable && pwrite;
    assign acc_r    = psel && penable && !pwrite;
    assign osc_tick = osc_s && !osc_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_h <= 1'b0;
            cfg_h  <= 1'b0;
        end
        else if (acc_w && paddr == CTRL_OFF)
        begin
            lock_h <= lock_h | pwdata[LOCK_BIT];
            cfg_h  <= 1'b1;
        end
    end

    // ticks since restart, seen with the same two-stage sync latency
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ticks <= 15'h0000;
            osc_m <= 1'b0;
            osc_s <= 1'b0;
            osc_q <= 1'b0;
        end
        else
        begin
            osc_m <= low_freq_osc;
            osc_s <= osc_m;
            osc_q <= osc_s;
            if (acc_w && paddr == KICK_OFF && pwdata[KEY_W-1:0] == KICK_KEY)
            begin
                ticks <= 15'h0000;
            end
            else if (osc_tick && ticks != 15'h7FFF)
            begin
                ticks <= ticks + 15'h0001;
            end
        end
    end

    // ********
    // assertions
    // ********
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pin_idle: assert property (ext_rst_pin_oe == 1'b0)
        else $error("reset pin driven");
    a_boot_state: assert property (reset_vector == 16'h0000 && boot_clk_internal)
        else $error("boot state wrong");
    a_req_sticky: assert property (sys_reset_req |=> sys_reset_req)
        else $error("reset request dropped");
    a_req_too_soon: assert property ($rose(sys_reset_req) |-> ticks >= 15'h0040)
        else $error("reset request before timeout");
    a_first_config: assert property (acc_r && paddr == CTRL_OFF && !cfg_h |-> prdata[4:0] == 5'h1D)
        else $error("reset configuration wrong");
    a_lock_holds: assert property (
        acc_r && (paddr == CTRL_OFF || paddr == STAT_OFF) && lock_h |-> prdata[1:0] == 2'b11)
        else $error("lock or enable lost");
    a_disable_quiet: assert property (
        acc_w && paddr == CTRL_OFF && !pwdata[EN_BIT] && !pwdata[LOCK_BIT]
        && !lock_h && !sys_reset_req |=> !sys_reset_req [*8])
        else $error("request while disabled");
    a_unmapped_err: assert property (psel && penable && paddr > COUNT_OFF |-> pslverr && pready)
        else $error("no error on unmapped address");
endmodule

bind lowfreq_watchdog_reset wdt_checker u_wdt_checker (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .low_freq_osc      (low_freq_osc),
    .sys_reset_req     (sys_reset_req),
    .ext_rst_pin_oe    (ext_rst_pin_oe),
    .reset_vector      (reset_vector),
    .boot_clk_internal (boot_clk_internal)
);
`default_nettype wire

/* File: verif/test_lowfreq_watchdog_reset.sv */
// self-checking bench for the low-frequency watchdog
`timescale 1ns/1ns
`default_nettype none
module test_lowfreq_watchdog_reset;
    import wdt_pkg::*;
    localparam int      HALF = 62;
    localparam int      TICK = 2 * HALF;
    logic               pclk, presetn, psel, penable, pwrite;
    logic               low_freq_osc = 1'b0;
    logic               pready, pslverr, sys_reset_req, ext_rst_pin_oe, boot_clk_internal, rd_e;
    logic [ADDR_W-1:0]  paddr;
    logic [31:0]        pwdata, prdata, rd_q;
    logic [15:0]        reset_vector;
    int                 err_total, compares, cyc;
    int                 osc_cnt = 0;

    lowfreq_watchdog_reset u_lowfreq_watchdog_reset (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .low_freq_osc      (low_freq_osc),
        .sys_reset_req     (sys_reset_req),
        .ext_rst_pin_oe    (ext_rst_pin_oe),
        .reset_vector      (reset_vector),
        .boot_clk_internal (boot_clk_internal)
    );

    // ********
    // clocks
    // ********
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        osc_cnt <= (osc_cnt == HALF - 1) ? 0 : osc_cnt + 1;
        if (osc_cnt == HALF - 1)
            low_freq_osc <= ~low_freq_osc;
    end

    // ********
    // tasks
    // ********
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd_q = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(rd_q, exp);
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic expect_trip;
        cyc = 0;
        while (sys_reset_req !== 1'b1 && cyc < 20000)
        begin
            @(posedge pclk);
            cyc++;
        end
        check({31'h0, cyc >= 63 * TICK && cyc <= 64 * TICK + 4}, 32'h1);
    endtask

    task automatic close_out;
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ********
    // tests
    // ********
    initial
    begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr  = '0;
        pwdata = 32'h0;
        err_total = 0;
        compares  = 0;
        do_reset();
        rd_chk(CTRL_OFF, 32'h0000001D);
        rd_chk(STAT_OFF, 32'h00000001);
        check({14'h0, ext_rst_pin_oe, boot_clk_internal, reset_vector}, 32'h00010000);
        rd_chk(12'h010, 32'h0);
        check({31'h0, rd_e}, 32'h1);
        wr(CTRL_OFF, 32'h1);
        wr(KICK_OFF, 32'hA5);
        xfer(COUNT_OFF, 1'b0, 32'h0);
        check({31'h0, rd_q < 32'h2}, 32'h1);
        repeat (20 * TICK) @(posedge pclk);
        xfer(COUNT_OFF, 1'b0, 32'h0);
        check({31'h0, rd_q >= 32'h12 && rd_q <= 32'h16}, 32'h1);
        wr(KICK_OFF, 32'h5A);
        xfer(COUNT_OFF, 1'b0, 32'h0);
        check({31'h0, rd_q >= 32'h12}, 32'h1);
        wr(KICK_OFF, 32'hA5);
        expect_trip();
        rd_chk(STAT_OFF, 32'h00000009);
        check({31'h0, ext_rst_pin_oe}, 32'h0);
        do_reset();
        rd_chk(CTRL_OFF, 32'h0000001D);
        wr(CTRL_OFF, 32'h0);
        repeat (70 * TICK) @(posedge pclk);
        check({31'h0, sys_reset_req}, 32'h0);
        rd_chk(STAT_OFF, 32'h0);
        wr(CTRL_OFF, 32'h2);
        rd_chk(CTRL_OFF, 32'h00000003);
        wr(CTRL_OFF, 32'h0);
        wr(CTRL_OFF, 32'h1C);
        rd_chk(CTRL_OFF, 32'h00000003);
        rd_chk(STAT_OFF, 32'h00000007);
        wr(STAT_OFF, 32'h4);
        rd_chk(STAT_OFF, 32'h00000003);
        wr(KICK_OFF, 32'hA5);
        expect_trip();
        close_out();
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
